// File: bench/eeprom_loader_model.sv
// eeprom side of the master-mode load, drives the block's loader inputs
// assumes the bench pulses start once the block reads as master
`timescale 1ns/1ps
module eeprom_loader_model (
   // bench control
   input  wire logic        clk,
   input  wire logic        start,
   input  wire logic        fail,
   input  wire logic [7:0]  lat,
   input  wire logic [6:0]  addr,
   input  wire logic [15:0] eq,
   input  wire logic [11:0] drv,
   // loader inputs of the block
   output logic             load_valid,
   output logic      [6:0]  load_addr,
   output logic      [15:0] load_eq,
   output logic      [11:0] load_drv,
   output logic             load_done,
   output logic             load_fail
);
   initial begin
      {load_valid, load_done, load_fail} = 3'h0;
      {load_addr, load_eq, load_drv} = '1;
      forever begin
         @(posedge clk);
         if (start) begin
            repeat (lat) @(posedge clk);
            // blank content gives no word at all
            load_valid <= !fail;
            {load_addr, load_eq, load_drv} <= {addr, eq, drv};
            @(posedge clk);
            load_valid <= 1'b0;
            // stale word must not look valid after the strobe
            {load_addr, load_eq, load_drv} <= ~{addr, eq, drv};
            load_done <= !fail;
            load_fail <= fail;
            @(posedge clk);
            {load_done, load_fail} <= 2'h0;
         end
      end
   end
endmodule

// File: bench/repeater_select_sva.sv
// checker on the ports of the repeater selection block
// assumes a bind from the bench onto repeater_select
`timescale 1ns/1ps
`include "repeater_cfg.svh"
module repeater_select_sva (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 nrst,
   // pins and loader
   input wire repeater_pkg::level_t mode_strap,
   input wire repeater_pkg::level_t side_a_equalizer_high_pin,
   input wire repeater_pkg::level_t side_a_equalizer_low_pin,
   input wire repeater_pkg::level_t swing_select_pin,
   input wire repeater_pkg::level_t detect_threshold_pin,
   input wire logic [1:0]           above_assert,
   input wire logic [1:0]           below_deassert,
   input wire logic                 load_done,
   input wire logic                 load_fail,
   // settings and status
   input wire logic [7:0]           eq_a,
   input wire logic [3:0]           threshold,
   input wire logic                 tx_disable,
   input wire logic [1:0]           out_enable,
   input wire logic [6:0]           slave_addr,
   input wire logic                 bus_release,
   input wire logic [1:0]           op_mode
);
   import repeater_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_load_ok;
      op_mode == MODE_MASTER && load_done;
   endsequence
   sequence s_load_bad;
      op_mode == MODE_MASTER && load_fail;
   endsequence
   a_pin_opmode: assert property (
      (mode_strap == LVL_ZERO) [*3] |-> op_mode == MODE_PIN)
      else $error("strap low but not pin mode");
   a_slave_opmode: assert property (
      (mode_strap == LVL_ONE) [*3] |-> op_mode == MODE_SLAVE ||
      (op_mode == MODE_MASTER && !bus_release))
      else $error("strap high but not slave mode");
   a_eq_top_code: assert property (
      mode_strap == LVL_ZERO && op_mode == MODE_PIN &&
      side_a_equalizer_high_pin == LVL_ONE &&
      side_a_equalizer_low_pin == LVL_ONE |-> eq_a == 8'hff)
      else $error("eq pins 11 not mapped to ff");
   a_thresh_float: assert property (
      mode_strap == LVL_ZERO && op_mode == MODE_PIN &&
      detect_threshold_pin == LVL_F |-> threshold == 4'h0)
      else $error("floating threshold pin not code 00");
   a_oen_on: assert property (
      (above_assert[0] && !below_deassert[0] && !tx_disable) [*2]
      |-> out_enable[0])
      else $error("output not enabled above assert");
   a_oen_off: assert property (
      below_deassert[1] |=> !out_enable[1])
      else $error("output enabled below deassert");
   a_load_release: assert property (
      s_load_ok |-> ##[1:4] (bus_release && op_mode == MODE_SLAVE))
      else $error("good load did not release the bus");
   a_load_stall: assert property (
      s_load_bad ##1 (mode_strap == LVL_F) [*8] |-> !bus_release)
      else $error("failed load granted the bus");
   a_addr_forced: assert property (
      op_mode != MODE_PIN && swing_select_pin == LVL_ONE
      |-> slave_addr == `ADDR_BASE)
      else $error("address straps not forced to zero");
endmodule

// File: bench/tb.sv
// self-checking bench of the repeater selection block
// assumes the eeprom model and checker are compiled before this file
`timescale 1ns/1ps
`include "repeater_cfg.svh"
module tb;
   import repeater_pkg::*;
   // ****************
   // signals
   // ****************
   logic        clk, nrst, psel, penable, pwrite, pready, start, fail;
   logic        transmit_disable_pin, mode_pin, tx_disable, bus_release;
   logic        mode_sel, pslverr;
   logic [2:0]  dem_a, dem_b, swing_a, swing_b;
   logic        load_valid, load_done, load_fail;
   logic [1:0]  above_assert, below_deassert, out_enable, op_mode;
   logic [3:0]  threshold;
   logic [6:0]  slave_addr, load_addr, addr;
   logic [7:0]  eq_a, eq_b, lat;
   logic [11:0] paddr, load_drv, drv;
   logic [15:0] load_eq, eq;
   logic [31:0] pwdata, prdata, rd, r;
   level_t      mode_strap, swing_select_pin, detect_threshold_pin;
   level_t      side_a_equalizer_high_pin, side_a_equalizer_low_pin;
   level_t      side_b_equalizer_high_pin, side_b_equalizer_low_pin;
   level_t      deemphasis_pin_a, deemphasis_pin_b;
   logic [7:0]  eq_tab [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15,
      8'h0b, 8'h0f, 8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf, 8'hff};
   logic [1:0]  th_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
   logic [5:0]  drv_tab [16] = '{6'h00, 6'h03, 6'h02, 6'h05, 6'h28, 6'h2b,
      6'h2a, 6'h2d, 6'h18, 6'h1b, 6'h1a, 6'h1d, 6'h20, 6'h31, 6'h21, 6'h32};
   logic [31:0] exp_q [$];
   int          id_q [$];
   int          errors, n_checks, k, seed;
   repeater_select u_repeater_select (.clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata, .mode_strap,
      .side_a_equalizer_high_pin, .side_a_equalizer_low_pin,
      .side_b_equalizer_high_pin, .side_b_equalizer_low_pin,
      .deemphasis_pin_a, .deemphasis_pin_b, .swing_select_pin,
      .detect_threshold_pin, .transmit_disable_pin, .mode_pin,
      .above_assert, .below_deassert, .load_valid, .load_addr, .load_eq,
      .load_drv, .load_done, .load_fail, .eq_a, .eq_b, .dem_a, .dem_b,
      .swing_a, .swing_b, .threshold, .tx_disable, .mode_sel,
      .out_enable, .slave_addr, .bus_release, .op_mode);
   eeprom_loader_model u_eeprom_loader_model (.clk, .start, .fail, .lat,
      .addr, .eq, .drv, .load_valid, .load_addr, .load_eq, .load_drv,
      .load_done, .load_fail);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************
   // shared tasks
   // ****************
   function automatic logic [31:0] obs(input int i);
      case (i)
         0: return rd;
         1: return 32'(eq_a);
         2: return 32'(eq_b);
         3: return 32'(threshold);
         4: return 32'(op_mode);
         5: return 32'(out_enable);
         6: return 32'(tx_disable);
         7: return 32'(slave_addr);
         8: return 32'(bus_release);
         9: return 32'({swing_b, dem_b, swing_a, dem_a});
         default: return 32'(mode_sel);
      endcase
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic miss(input logic [31:0] e, input logic [31:0] g);
      errors++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
   endtask
   task automatic chk(input int i, input logic [31:0] v);
      id_q.push_back(i);
      exp_q.push_back(v);
   endtask
   // compared on the falling edge, where outputs have settled
   always @(negedge clk) begin
      while (exp_q.size() > 0) begin
         n_checks++;
         if (obs(id_q[0]) !== exp_q[0]) miss(exp_q[0], obs(id_q[0]));
         exp_q.delete(0);
         id_q.delete(0);
      end
   end
   task automatic wait_for(input int i, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (obs(i) !== v && n < 60);
      n_checks++;
      if (obs(i) !== v) begin
         miss(v, obs(i));
         end_of_test;
      end
      @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miss(32'h1, 32'(pready));
         end_of_test;
      end
      rd = prdata;
      n_checks++;
      if (pslverr !== 1'b0) miss(32'h0, 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so no signal is driven twice in one step
      @(posedge clk);
   endtask
   // ****************
   // scenarios
   // ****************
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, start, fail} = '0;
      {transmit_disable_pin, mode_pin, above_assert, below_deassert} = '0;
      {lat, addr, eq, drv, errors, n_checks} = '0;
      mode_strap = LVL_ZERO;
      swing_select_pin = LVL_ZERO;
      detect_threshold_pin = LVL_F;
      side_a_equalizer_high_pin = LVL_ZERO;
      side_a_equalizer_low_pin = LVL_ZERO;
      side_b_equalizer_high_pin = LVL_ZERO;
      side_b_equalizer_low_pin = LVL_ZERO;
      deemphasis_pin_a = LVL_ZERO;
      deemphasis_pin_b = LVL_ZERO;
      seed = $urandom(8196);
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         r = $urandom_range(15);
         side_a_equalizer_high_pin <= level_t'(k[3:2]);
         side_a_equalizer_low_pin <= level_t'(k[1:0]);
         side_b_equalizer_high_pin <= level_t'(r[3:2]);
         side_b_equalizer_low_pin <= level_t'(r[1:0]);
         detect_threshold_pin <= level_t'(k[1:0]);
         swing_select_pin <= level_t'(k[3:2]);
         deemphasis_pin_a <= level_t'(k[1:0]);
         deemphasis_pin_b <= level_t'(r[1:0]);
         chk(9, 32'({drv_tab[{k[3:2], r[1:0]}], drv_tab[k]}));
         chk(1, 32'(eq_tab[k]));
         chk(2, 32'(eq_tab[r[3:0]]));
         chk(3, 32'({2{th_tab[k[1:0]]}}));
      end
      @(posedge clk);
      above_assert <= 2'h3;
      repeat (2) @(posedge clk);
      above_assert <= 2'h0;
      wait_for(5, 32'h3);
      below_deassert <= 2'h2;
      wait_for(5, 32'h1);
      transmit_disable_pin <= 1'b1;
      mode_pin <= 1'b1;
      wait_for(5, 32'h0);
      chk(6, 32'h1);
      chk(10, 32'h1);
      $display("pin mode test done");
      side_a_equalizer_high_pin <= LVL_ZERO;
      side_a_equalizer_low_pin <= LVL_ZERO;
      side_b_equalizer_high_pin <= LVL_ZERO;
      side_b_equalizer_low_pin <= LVL_ZERO;
      swing_select_pin <= LVL_ZERO;
      deemphasis_pin_a <= LVL_ZERO;
      deemphasis_pin_b <= LVL_ZERO;
      mode_strap <= LVL_ONE;
      wait_for(4, 32'h1);
      chk(7, 32'(`ADDR_BASE));
      chk(1, 32'h2f);
      apb(1'b1, `OFS_EQ, 32'h1234);
      chk(1, 32'h2f);
      apb(1'b0, `OFS_EQ, 32'h0);
      chk(0, 32'(`EQ_RESET));
      apb(1'b1, `OFS_CTRL, 32'h8);
      r = $urandom;
      apb(1'b1, `OFS_EQ, r);
      chk(1, 32'(r[7:0]));
      chk(2, 32'(r[15:8]));
      side_a_equalizer_high_pin <= LVL_ONE;
      detect_threshold_pin <= LVL_ZERO;
      swing_select_pin <= LVL_ONE;
      chk(1, 32'(r[7:0]));
      chk(3, 32'ha);
      chk(7, 32'(`ADDR_BASE));
      apb(1'b0, `OFS_EQ, 32'h0);
      chk(0, 32'(r[15:0]));
      chk(6, 32'h1);
      apb(1'b1, `OFS_CTRL, 32'ha78);
      chk(3, 32'h5);
      chk(10, 32'h0);
      chk(6, 32'h0);
      detect_threshold_pin <= LVL_ONE;
      chk(3, 32'h5);
      apb(1'b0, 12'h03c, 32'h0);
      chk(0, 32'h0);
      mode_strap <= LVL_ZERO;
      wait_for(4, 32'h0);
      chk(3, 32'hf);
      chk(10, 32'h1);
      mode_strap <= LVL_ONE;
      wait_for(4, 32'h1);
      chk(3, 32'hf);
      $display("slave mode test done");
      mode_strap <= LVL_F;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      wait_for(4, 32'h3);
      eq <= 16'($urandom);
      drv <= 12'($urandom);
      addr <= `ADDR_BASE;
      lat <= 8'($urandom_range(20, 1));
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_for(8, 32'h1);
      chk(4, 32'h1);
      chk(9, 32'(`DRV_RESET));
      apb(1'b0, `OFS_EQ, 32'h0);
      chk(0, 32'(eq));
      apb(1'b0, `OFS_DRV, 32'h0);
      chk(0, 32'(drv));
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(0, 32'h0);
      mode_strap <= LVL_ZERO;
      wait_for(4, 32'h0);
      mode_strap <= LVL_F;
      fail <= 1'b1;
      wait_for(4, 32'h3);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (40) @(posedge clk);
      chk(8, 32'h0);
      chk(4, 32'h3);
      apb(1'b1, `OFS_CTRL, 32'h8);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(0, 32'h0);
      repeat (2) @(posedge clk);
      $display("eeprom load test done");
      end_of_test;
   end
endmodule
bind repeater_select repeater_select_sva u_repeater_select_sva (.clk, .nrst,
   .mode_strap, .side_a_equalizer_high_pin, .side_a_equalizer_low_pin,
   .swing_select_pin, .detect_threshold_pin, .above_assert, .below_deassert,
   .load_done, .load_fail, .eq_a, .threshold, .tx_disable, .out_enable,
   .slave_addr, .bus_release, .op_mode);

// File: rtl/repeater_cfg.svh
// constants of the repeater mode and setting selection block
// assumes inclusion by rtl and bench files; offsets are byte addresses on apb
`ifndef REPEATER_CFG_SVH
`define REPEATER_CFG_SVH

`define OFS_CTRL       12'h000
`define OFS_EQ         12'h004
`define OFS_DRV        12'h008
`define OFS_STATUS     12'h00c
`define OFS_LOAD       12'h010

`define CTRL_REG_EN    3
`define CTRL_OVR_TXD   4
`define CTRL_OVR_MODE  5
`define CTRL_OVR_TH    6
`define CTRL_TXD       7
`define CTRL_MODE      8
`define CTRL_TH_LO     9
`define CTRL_TH_HI     12

`define EQ_RESET       16'h2f2f
`define DRV_RESET      12'h000
`define TH_RESET       4'h0
`define ADDR_BASE      7'h58
`define LOAD_ERR_BIT   1

`endif

// File: rtl/repeater_pkg.sv
// types of the repeater mode and setting selection block
// assumes repeater_cfg.svh for numeric constants
package repeater_pkg;
   // four-level pin state, ordered 0, R, F, 1
   typedef enum logic [1:0] {
      LVL_ZERO = 2'b00,
      LVL_R    = 2'b01,
      LVL_F    = 2'b10,
      LVL_ONE  = 2'b11
   } level_t;

   typedef enum logic [1:0] {
      MODE_PIN    = 2'b00,
      MODE_SLAVE  = 2'b01,
      MODE_MASTER = 2'b11
   } opmode_t;

   // gray along idle -> loading -> done; stall off the path
   typedef enum logic [1:0] {
      LD_IDLE  = 2'b00,
      LD_BUSY  = 2'b01,
      LD_DONE  = 2'b11,
      LD_STALL = 2'b10
   } load_state_t;
endpackage

// File: rtl/repeater_select.sv
// mode and setting selection of a one-lane bidirectional repeater
// assumes pin levels already resolved by the analog level comparators,
// apb master on clk, and an eeprom loader that presents words and a verdict
//
// Overview of operation
// - mode strap low picks pin mode, high slave, floating master with eeprom.
// - each output is off below de-assert level, on above assert level.
// - four-level inputs resolve to 0, R, F, 1 at 0.2, 0.5, 0.8 supply.
// - four-level eq, de-emphasis and swing pins set conditioning only while in pin control mode.
// - pin mode sets eq and de-emphasis per side, threshold from its pin.
// - slave mode hands eq, de-emphasis and swing to registers at once.
// - register settings stay default until register-enable bit is set.
// - in bus modes eq, de-emphasis and swing pins become address straps.
// - in slave mode disable, mode, threshold pins act unless overridden.
// - an overridden pin stays ignored until a ctrl write clears its override bit or the strap returns to pin mode.
// - transmit disable leaves all register contents unchanged.
// - threshold codes: 0 to 10, R to 01, F to 00, 1 to 11.
// - master mode takes register settings from eeprom by slave address.
// - eeprom load covers only a subset of register bits; rest keep default.
// - after a good load the device goes to slave mode, releases the bus.
// - a failed load stalls the device with no bus access until the strap returns to pin mode.
// - pin mode reaches sixteen eq codes; registers reach all 256.
// - swing and de-emphasis pin pairs program a fixed combined setting.
// - eq pairs 00,0R,0F,01,R0,RR,RF,R1 give 00,01,02,03,07,15,0b,0f.
// - eq pairs F0,FR,FF,F1,10,1R,1F,11 give 55,1f,2f,3f,aa,7f,bf,ff.
// - undriven straps read zero for the default address; sixteen addresses.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "repeater_cfg.svh"

module repeater_select (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic      [31:0]            prdata,
   // strap, four-level and two-level pin levels
   input  wire repeater_pkg::level_t   mode_strap,
   input  wire repeater_pkg::level_t   side_a_equalizer_high_pin,
   input  wire repeater_pkg::level_t   side_a_equalizer_low_pin,
   input  wire repeater_pkg::level_t   side_b_equalizer_high_pin,
   input  wire repeater_pkg::level_t   side_b_equalizer_low_pin,
   input  wire repeater_pkg::level_t   deemphasis_pin_a,
   input  wire repeater_pkg::level_t   deemphasis_pin_b,
   input  wire repeater_pkg::level_t   swing_select_pin,
   input  wire repeater_pkg::level_t   detect_threshold_pin,
   input  wire logic                   transmit_disable_pin,
   input  wire logic                   mode_pin,
   // signal detectors per channel
   input  wire logic [1:0]             above_assert,
   input  wire logic [1:0]             below_deassert,
   // eeprom loader
   input  wire logic                   load_valid,
   input  wire logic [6:0]             load_addr,
   input  wire logic [15:0]            load_eq,
   input  wire logic [11:0]            load_drv,
   input  wire logic                   load_done,
   input  wire logic                   load_fail,
   // conditioning settings out
   output logic      [7:0]             eq_a,
   output logic      [7:0]             eq_b,
   output logic      [2:0]             dem_a,
   output logic      [2:0]             dem_b,
   output logic      [2:0]             swing_a,
   output logic      [2:0]             swing_b,
   output logic      [3:0]             threshold,
   output logic                        tx_disable,
   output logic                        mode_sel,
   output logic      [1:0]             out_enable,
   // serial bus status
   output logic      [6:0]             slave_addr,
   output logic                        bus_release,
   output logic      [1:0]             op_mode
);
   import repeater_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0]  rdata;
      logic [12:0]  ctrl;
      logic [15:0]  eq;
      logic [11:0]  drv;
      logic [1:0]   oen;
      load_state_t  ld;
      logic         err;
      opmode_t      mode;
   } state_t;

   state_t st;
   state_t next_st;

   // ************************************************************
   // decoding functions
   // ************************************************************
   function automatic opmode_t strap_mode(input level_t l);
      case (l)
         LVL_ZERO, LVL_R: strap_mode = MODE_PIN;
         LVL_ONE:         strap_mode = MODE_SLAVE;
         default:         strap_mode = MODE_MASTER;
      endcase
   endfunction

   // pin pair to eq code, high pin first
   function automatic logic [7:0] eq_code(input level_t hi, input level_t lo);
      case ({hi, lo})
         {LVL_ZERO, LVL_ZERO}: eq_code = 8'h00;
         {LVL_ZERO, LVL_R}:    eq_code = 8'h01;
         {LVL_ZERO, LVL_F}:    eq_code = 8'h02;
         {LVL_ZERO, LVL_ONE}:  eq_code = 8'h03;
         {LVL_R, LVL_ZERO}:    eq_code = 8'h07;
         {LVL_R, LVL_R}:       eq_code = 8'h15;
         {LVL_R, LVL_F}:       eq_code = 8'h0b;
         {LVL_R, LVL_ONE}:     eq_code = 8'h0f;
         {LVL_F, LVL_ZERO}:    eq_code = 8'h55;
         {LVL_F, LVL_R}:       eq_code = 8'h1f;
         {LVL_F, LVL_F}:       eq_code = 8'h2f;
         {LVL_F, LVL_ONE}:     eq_code = 8'h3f;
         {LVL_ONE, LVL_ZERO}:  eq_code = 8'haa;
         {LVL_ONE, LVL_R}:     eq_code = 8'h7f;
         {LVL_ONE, LVL_F}:     eq_code = 8'hbf;
         default:              eq_code = 8'hff;
      endcase
   endfunction

   function automatic logic [1:0] th_code(input level_t l);
      case (l)
         LVL_ZERO: th_code = 2'b10;
         LVL_R:    th_code = 2'b01;
         LVL_F:    th_code = 2'b00;
         default:  th_code = 2'b11;
      endcase
   endfunction

   // fixed swing and de-emphasis pair: {swing, dem}
   function automatic logic [5:0] drv_code(input level_t sw, input level_t d);
      logic [2:0] s;
      logic [2:0] e;
      s = 3'h0;
      e = 3'h0;
      case (d)
         LVL_ZERO: e = 3'h0;
         LVL_F:    e = 3'h2;
         LVL_R:    e = 3'h3;
         default:  e = 3'h5;
      endcase
      case (sw)
         LVL_ZERO: s = 3'h0;
         LVL_F:    s = 3'h3;
         LVL_R:    s = 3'h5;
         default: begin
            case (d)
               LVL_ZERO: begin
                  s = 3'h4;
                  e = 3'h0;
               end
               LVL_F: begin
                  s = 3'h4;
                  e = 3'h1;
               end
               LVL_R: begin
                  s = 3'h6;
                  e = 3'h1;
               end
               default: begin
                  s = 3'h6;
                  e = 3'h2;
               end
            endcase
         end
      endcase
      drv_code = {s, e};
   endfunction

   // ************************************************************
   // combinational derivation
   // ************************************************************
   opmode_t     strap;
   logic [3:0]  straps;
   logic [6:0]  my_addr;
   logic        wr;
   logic        rd;
   logic [5:0]  pin_drv_a;
   logic [5:0]  pin_drv_b;

   assign strap = strap_mode(mode_strap);
   // only level 1 counts as a strap high; float reads low by pull-down
   assign straps = (swing_select_pin == LVL_ONE) ? 4'h0 :
                   {side_a_equalizer_high_pin == LVL_ONE,
                    side_b_equalizer_high_pin == LVL_ONE,
                    deemphasis_pin_a == LVL_ONE,
                    deemphasis_pin_b == LVL_ONE};
   assign my_addr = 7'(`ADDR_BASE + {3'h0, straps});
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pin_drv_a = drv_code(swing_select_pin, deemphasis_pin_a);
   assign pin_drv_b = drv_code(swing_select_pin, deemphasis_pin_b);

   // ************************************************************
   // next state
   // ************************************************************

   always_comb begin
      next_st = st;
      // strap back at pin mode drops every override
      if (strap == MODE_PIN) begin
         next_st.ctrl[`CTRL_OVR_TXD]  = 1'b0;
         next_st.ctrl[`CTRL_OVR_MODE] = 1'b0;
         next_st.ctrl[`CTRL_OVR_TH]   = 1'b0;
         next_st.ld   = LD_IDLE;
         next_st.mode = MODE_PIN;
      end else if (strap == MODE_SLAVE && st.ld != LD_STALL) begin
         next_st.mode = MODE_SLAVE;
      end else if (strap == MODE_MASTER && st.ld == LD_IDLE) begin
         next_st.ld   = LD_BUSY;
         next_st.mode = MODE_MASTER;
      end
      // eeprom load; only eq and drive words are carried
      if (st.ld == LD_BUSY) begin
         if (load_valid && load_addr == my_addr) begin
            next_st.eq  = load_eq;
            next_st.drv = load_drv;
         end
         // a failed load holds the stall until the strap goes to pin mode
         if (load_fail) begin
            next_st.ld  = LD_STALL;
            next_st.err = 1'b1;
         end else if (load_done) begin
            next_st.ld   = LD_DONE;
            next_st.mode = MODE_SLAVE;
         end
      end
      // apb writes; transmit disable never touches these
      if (wr && st.mode == MODE_SLAVE) begin
         if (paddr == `OFS_CTRL) begin
            next_st.ctrl = pwdata[12:0];
         end else if (paddr == `OFS_EQ && st.ctrl[`CTRL_REG_EN]) begin
            next_st.eq = pwdata[15:0];
         end else if (paddr == `OFS_DRV && st.ctrl[`CTRL_REG_EN]) begin
            next_st.drv = pwdata[11:0];
         end
      end
      // captured in setup so the word stands through the access phase
      if (rd) begin
         if (paddr == `OFS_CTRL) begin
            next_st.rdata = {19'h0, st.ctrl};
         end else if (paddr == `OFS_EQ) begin
            next_st.rdata = {16'h0, st.eq};
         end else if (paddr == `OFS_DRV) begin
            next_st.rdata = {20'h0, st.drv};
         end else if (paddr == `OFS_STATUS) begin
            next_st.rdata = {23'h0, my_addr, st.mode};
         end else if (paddr == `OFS_LOAD) begin
            next_st.rdata = {29'h0, st.err, st.ld};
         end else begin
            next_st.rdata = 32'h0;
         end
      end
      // detector hysteresis per channel
      for (int i = 0; i < 2; i++) begin
         if (below_deassert[i]) begin
            next_st.oen[i] = 1'b0;
         end else if (above_assert[i]) begin
            next_st.oen[i] = 1'b1;
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st.rdata <= 32'h0;
         st.ctrl  <= {`TH_RESET, 9'h0};
         st.eq    <= `EQ_RESET;
         st.drv   <= `DRV_RESET;
         st.oen   <= 2'b00;
         st.ld    <= LD_IDLE;
         st.err   <= 1'b0;
         st.mode  <= MODE_PIN;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // apb answer and outputs
   // ************************************************************
   logic pin_mode;
   logic [11:0] reg_drv;

   assign pin_mode = (st.mode == MODE_PIN);
   // defaults hold until the enable bit lets written values through
   assign reg_drv  = st.ctrl[`CTRL_REG_EN] ? st.drv : `DRV_RESET;
   assign pready   = 1'b1;
   assign pslverr  = 1'b0;
   assign prdata   = st.rdata;

   always_comb begin
      if (pin_mode) begin
         eq_a    = eq_code(side_a_equalizer_high_pin,
                           side_a_equalizer_low_pin);
         eq_b    = eq_code(side_b_equalizer_high_pin,
                           side_b_equalizer_low_pin);
         swing_a = pin_drv_a[5:3];
         dem_a   = pin_drv_a[2:0];
         swing_b = pin_drv_b[5:3];
         dem_b   = pin_drv_b[2:0];
      end else begin
         eq_a    = st.ctrl[`CTRL_REG_EN] ? st.eq[7:0] :
                   8'(`EQ_RESET);
         eq_b    = st.ctrl[`CTRL_REG_EN] ? st.eq[15:8] :
                   8'(`EQ_RESET >> 8);
         swing_a = reg_drv[5:3];
         dem_a   = reg_drv[2:0];
         swing_b = reg_drv[11:9];
         dem_b   = reg_drv[8:6];
      end
      if (!pin_mode && st.ctrl[`CTRL_OVR_TH]) begin
         threshold = st.ctrl[`CTRL_TH_HI:`CTRL_TH_LO];
      end else begin
         threshold = {2{th_code(detect_threshold_pin)}};
      end
      // overrides count only outside pin mode; the strap clears them there
      tx_disable = (!pin_mode && st.ctrl[`CTRL_OVR_TXD]) ?
                   st.ctrl[`CTRL_TXD] : transmit_disable_pin;
      mode_sel   = (!pin_mode && st.ctrl[`CTRL_OVR_MODE]) ?
                   st.ctrl[`CTRL_MODE] : mode_pin;
   end

   assign out_enable  = st.oen & {2{!tx_disable}};
   assign slave_addr  = my_addr;
   // stalled or loading devices keep off the bus
   assign bus_release = (st.mode == MODE_SLAVE) && (st.ld != LD_STALL);
   assign op_mode     = st.mode;
endmodule
